// >>> src/lpwd_top.sv
// Operation
// (R1) Slow-select codes 000 to 110 pick fast clock divided by 1 to 64.
// (R2) Software polls oscillator-stable flag before relying on fast mode.
// (R3) Halt with both keep bits low enters sleep, only watchdog runs.
// (R4) Halt with only slow keep set enters slow-only idle.
// (R5) Halt with both keep bits set enters idle with both clocks.
// (R6) Halt with only fast keep set enters fast-only idle.
// (R7) Any power-down entry keeps state, sets powerdown, clears timeout flag.
// (R8) Halt clears watchdog counter; it then runs only if enabled.
// (R9) Power-down wakes on enabled port A fall, interrupt, or overflow.
// (R10) Powerdown flag cleared by power-up or clear instruction, set by halt.
// (R11) Overflow in power-down sets timeout, wakes, resets only PC and SP.
// (R12) Per-pin wake enables; pin wake resumes after halt.
// (R13) Disabled interrupt or full stack wake resumes after halt.
// (R14) Enabled interrupt with stack room wakes into normal interrupt response.
// (R15) Interrupt already pending before halt cannot wake the device.
// (R16) Watchdog counts low RC clock edges, divided to a time-out.
// (R17) Period codes give 2^8 to 2^18 low RC clock periods.
// (R18) Key 10101 disables, 01010 enables, other values request reset.
// (R19) Invalid key resets after software reset delay, sets key-reset flag.
// (R20) Overflow while running gives full device reset and sets timeout.
// (R21) Clear instruction clears the watchdog counter.
// (R22) Oscillator-stable flag reads 0 after enable, 1 once stable.
// (R23) Watchdog is an 18-bit counter compared against selected period.
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lpwd_top
	import lpwd_pkg::*;
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic WB_CYC,
	input wire logic WB_STB,
	input wire logic WB_WE,
	input wire logic [7:0] WB_ADR,
	input wire logic [3:0] WB_SEL,
	input wire logic [31:0] WB_DAT_W,
	output logic [31:0] WB_DAT_R,
	output logic WB_ACK,
	input wire logic HALT_EXEC,
	input wire logic WDCLR_EXEC,
	input wire logic [7:0] INT_REQ,
	input wire logic [7:0] INT_EN,
	input wire logic STACK_FULL,
	input wire logic [PA_W-1:0] PORT_A,
	input wire logic LRC_CLK_IN,
	input wire logic HSOSC_READY,
	output logic [2:0] SYSCLK_SEL,
	output lpwd_gates_t CLK_GATES,
	output logic WAKE_RESUME,
	output logic WAKE_IRQ,
	output logic PC_SP_RESET,
	output logic DEVICE_RESET
);
	logic [PA_W+1:0] pins;
	logic [PA_W-1:0] pa_s;
	logic [PA_W-1:0] pa_prev;
	logic lrc_s;
	logic lrc_prev;
	logic rdy_s;
	logic [2:0] sysclk_select;
	logic fast_keep;
	logic slow_keep;
	logic hsosc_enable;
	logic hs_flag;
	logic hs_on_prev;
	logic [7:0] wd_ctrl;
	logic [PA_W-1:0] pa_wake_en;
	logic powerdown;
	logic timeout;
	logic key_reset_flag;
	lpwd_mode_t mode;
	lpwd_mode_t next_mode;
	logic [7:0] int_armed;
	logic [WD_W-1:0] wd_cnt;
	logic [11:0] srst_cnt;
	logic wb_req;
	logic wr_en;
	logic halt_take;
	logic lrc_tick;
	logic wd_en;
	logic key_bad;
	logic wd_ovf;
	logic srst_done;
	logic dev_rst;
	logic asleep;
	logic [PA_W-1:0] pa_fall;
	logic pin_wake;
	logic [7:0] int_hit;
	logic int_wake;
	logic irq_serve;
	logic [7:0] rd_byte;

	// Pins and low RC clock pass the three-stage filter
	assign pins = {HSOSC_READY, LRC_CLK_IN, PORT_A};
	lpwd_pin_sync #(.W(PA_W + 2)) u_sync (
		.clk(CLK),
		.rst_n(RESETN),
		.din(pins),
		.dout({rdy_s, lrc_s, pa_s})
	);

	// Edge history of filtered inputs and of the fast oscillator gate
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			pa_prev <= '0;
			lrc_prev <= 1'b0;
			hs_on_prev <= 1'b0;
		end else begin
			pa_prev <= pa_s;
			lrc_prev <= lrc_s;
			hs_on_prev <= CLK_GATES.hs_on;
		end
	end

	// Bus decode and event terms
	assign wb_req = WB_CYC & WB_STB;
	assign wr_en = wb_req & WB_WE & WB_ACK & WB_SEL[0];
	assign asleep = (mode != MODE_RUN);
	assign halt_take = HALT_EXEC & ~asleep;
	assign lrc_tick = lrc_s & ~lrc_prev; // [R16]
	assign wd_en = (wd_ctrl[WDKEY_MSB:WDKEY_LSB] == KEY_EN); // [R18]
	assign key_bad = ~wd_en & (wd_ctrl[WDKEY_MSB:WDKEY_LSB] != KEY_DIS); // [R18]
	assign wd_ovf = wd_en & lrc_tick & (wd_cnt == wd_limit(wd_ctrl[WDSEL_MSB:WDSEL_LSB])); // [R17]
	assign srst_done = key_bad & (srst_cnt == 12'(SRESET_CYC - 1)); // [R19]
	assign dev_rst = srst_done | (wd_ovf & ~asleep); // [R20]
	assign pa_fall = pa_prev & ~pa_s & pa_wake_en; // [R12]
	assign pin_wake = asleep & (pa_fall != '0); // [R9]
	assign int_hit = INT_REQ & int_armed; // [R15]
	assign int_wake = asleep & (int_hit != '0); // [R9]
	assign irq_serve = ((int_hit & INT_EN) != '0) & ~STACK_FULL; // [R14]

	// Bus acknowledge, one cycle per request
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			WB_ACK <= 1'b0;
		end else begin
			WB_ACK <= wb_req & ~WB_ACK;
		end
	end

	// Read mux, unmapped offsets read zero
	always_comb begin
		rd_byte = 8'h00;
		unique case (WB_ADR)
			OFS_SYSCLK: rd_byte = {sysclk_select, 3'h0, fast_keep, slow_keep};
			OFS_HSOSC: rd_byte = {6'h00, hs_flag, hsosc_enable};
			OFS_WDOG: rd_byte = wd_ctrl;
			OFS_PAWAKE: rd_byte = pa_wake_en;
			OFS_STATUS: rd_byte = {3'h0, 3'(mode), timeout, powerdown};
			OFS_RSTCAUSE: rd_byte = {7'h00, key_reset_flag};
			default: rd_byte = 8'h00;
		endcase
	end

	// Read data latched with the acknowledge
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			WB_DAT_R <= '0;
		end else if (wb_req & ~WB_ACK & ~WB_WE) begin
			WB_DAT_R <= {24'h000000, rd_byte};
		end
	end

	// Software control registers, restored by a device reset
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			sysclk_select <= SYSCLK_RST[SYSSEL_MSB:SYSSEL_LSB];
			fast_keep <= SYSCLK_RST[FKEEP_BIT];
			slow_keep <= SYSCLK_RST[SKEEP_BIT];
			hsosc_enable <= HSOSC_RST[HSEN_BIT];
			wd_ctrl <= WDOG_RST;
			pa_wake_en <= PAWAKE_RST;
		end else if (DEVICE_RESET) begin
			sysclk_select <= SYSCLK_RST[SYSSEL_MSB:SYSSEL_LSB];
			fast_keep <= SYSCLK_RST[FKEEP_BIT];
			slow_keep <= SYSCLK_RST[SKEEP_BIT];
			hsosc_enable <= HSOSC_RST[HSEN_BIT];
			wd_ctrl <= WDOG_RST;
			pa_wake_en <= PAWAKE_RST;
		end else if (wr_en) begin
			if (WB_ADR == OFS_SYSCLK) begin
				sysclk_select <= WB_DAT_W[SYSSEL_MSB:SYSSEL_LSB];
				fast_keep <= WB_DAT_W[FKEEP_BIT];
				slow_keep <= WB_DAT_W[SKEEP_BIT];
			end
			if (WB_ADR == OFS_HSOSC) begin
				hsosc_enable <= WB_DAT_W[HSEN_BIT];
			end
			if (WB_ADR == OFS_WDOG) begin
				wd_ctrl <= WB_DAT_W[7:0];
			end
			if (WB_ADR == OFS_PAWAKE) begin
				pa_wake_en <= WB_DAT_W[PA_W-1:0];
			end
		end
	end

	// Key-reset flag: hardware set wins over software clear
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			key_reset_flag <= 1'b0;
		end else if (srst_done) begin
			key_reset_flag <= 1'b1; // [R19]
		end else if (wr_en && WB_ADR == OFS_RSTCAUSE && !WB_DAT_W[WRF_BIT]) begin
			key_reset_flag <= 1'b0;
		end
	end

	// Delay from invalid key to device reset
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			srst_cnt <= '0;
		end else if (!key_bad || srst_done) begin
			srst_cnt <= '0;
		end else begin
			srst_cnt <= srst_cnt + 12'h001; // [R19]
		end
	end

	// Watchdog counter on the low RC clock
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			wd_cnt <= '0;
		end else if (halt_take || WDCLR_EXEC || key_bad || wd_ovf || DEVICE_RESET) begin
			wd_cnt <= '0; // [R8] [R21] [R23]
		end else if (wd_en && lrc_tick) begin
			wd_cnt <= wd_cnt + 18'h00001; // [R16] [R23]
		end
	end

	// Mode chosen by the keep bits on halt
	always_comb begin
		next_mode = mode;
		if (halt_take) begin
			unique case ({fast_keep, slow_keep})
				2'b00: next_mode = MODE_SLEEP; // [R3]
				2'b01: next_mode = MODE_IDLE_SLOW; // [R4]
				2'b11: next_mode = MODE_IDLE_BOTH; // [R5]
				2'b10: next_mode = MODE_IDLE_FAST; // [R6]
			endcase
		end else if (pin_wake || int_wake || (wd_ovf && asleep)) begin
			next_mode = MODE_RUN; // [R9]
		end
	end

	// Power mode register
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			mode <= MODE_RUN;
		end else if (DEVICE_RESET) begin
			mode <= MODE_RUN;
		end else begin
			mode <= next_mode;
		end
	end

	// Interrupts armed for wake-up only if not pending at halt
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			int_armed <= '0;
		end else if (halt_take) begin
			int_armed <= ~INT_REQ; // [R15]
		end else if (!asleep) begin
			int_armed <= '0;
		end
	end

	// Powerdown and timeout status flags
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			powerdown <= 1'b0;
			timeout <= 1'b0;
		end else begin
			if (halt_take) begin
				powerdown <= 1'b1; // [R7] [R10]
			end else if (WDCLR_EXEC) begin
				powerdown <= 1'b0; // [R10]
			end
			if (wd_ovf) begin
				timeout <= 1'b1; // [R11] [R20]
			end else if (halt_take) begin
				timeout <= 1'b0; // [R7]
			end
		end
	end

	// Wake and reset pulses to the CPU sequencer
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			WAKE_RESUME <= 1'b0;
			WAKE_IRQ <= 1'b0;
			PC_SP_RESET <= 1'b0;
			DEVICE_RESET <= 1'b0;
		end else begin
			PC_SP_RESET <= wd_ovf & asleep; // [R11]
			WAKE_IRQ <= asleep & ~wd_ovf & int_wake & irq_serve; // [R14]
			WAKE_RESUME <= asleep & ~wd_ovf & ~halt_take & (pin_wake | (int_wake & ~irq_serve)); // [R12] [R13]
			DEVICE_RESET <= dev_rst; // [R19] [R20]
		end
	end

	// System clock source and gates per mode
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			SYSCLK_SEL <= SYSCLK_RST[SYSSEL_MSB:SYSSEL_LSB];
			CLK_GATES <= '0;
		end else begin
			SYSCLK_SEL <= sysclk_select; // [R1]
			CLK_GATES.cpu_run <= (mode == MODE_RUN); // [R3]
			CLK_GATES.wd_run <= wd_en;
			CLK_GATES.hs_on <= (mode == MODE_RUN) ? (hsosc_enable | (sysclk_select != SEL_SLOW))
				: (mode == MODE_IDLE_BOTH || mode == MODE_IDLE_FAST); // [R4] [R5] [R6]
			CLK_GATES.ls_on <= (mode == MODE_RUN || mode == MODE_IDLE_SLOW
				|| mode == MODE_IDLE_BOTH); // [R3] [R6]
		end
	end

	// Oscillator-stable flag, low for two cycles after enable
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			hs_flag <= 1'b0;
		end else begin
			hs_flag <= CLK_GATES.hs_on & hs_on_prev & rdy_s; // [R22]
		end
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);

	a_sysclk_follow: assert property (wr_en && WB_ADR == OFS_SYSCLK |=> ##1 // [R1]
		SYSCLK_SEL == $past(WB_DAT_W[SYSSEL_MSB:SYSSEL_LSB], 2))
		else $error("system clock select not applied");
	a_sleep_entry: assert property (halt_take && !fast_keep && !slow_keep |=> // [R3]
		mode == MODE_SLEEP ##1 !CLK_GATES.cpu_run && !CLK_GATES.hs_on && !CLK_GATES.ls_on)
		else $error("sleep entry wrong");
	a_idle_slow: assert property (halt_take && !fast_keep && slow_keep |=> // [R4]
		mode == MODE_IDLE_SLOW ##1 CLK_GATES.ls_on && !CLK_GATES.hs_on)
		else $error("slow-only idle entry wrong");
	a_idle_both: assert property (halt_take && fast_keep && slow_keep |=> // [R5]
		mode == MODE_IDLE_BOTH ##1 CLK_GATES.ls_on && CLK_GATES.hs_on)
		else $error("both-clock idle entry wrong");
	a_idle_fast: assert property (halt_take && fast_keep && !slow_keep |=> // [R6]
		mode == MODE_IDLE_FAST ##1 !CLK_GATES.ls_on && CLK_GATES.hs_on)
		else $error("fast-only idle entry wrong");
	a_halt_flags: assert property (halt_take && !wd_ovf |=> powerdown && !timeout) // [R7]
		else $error("halt flags wrong");
	a_halt_wd_clear: assert property (halt_take |=> wd_cnt == '0) // [R8]
		else $error("halt did not clear watchdog");
	a_wdclr_pd: assert property (WDCLR_EXEC && !halt_take |=> !powerdown) // [R10]
		else $error("clear instruction left powerdown set");
	a_ovf_sleep: assert property (wd_ovf && asleep |=> // [R11]
		PC_SP_RESET && timeout && mode == MODE_RUN && !DEVICE_RESET)
		else $error("overflow wake wrong");
	a_ovf_run: assert property (wd_ovf && !asleep |=> DEVICE_RESET && timeout) // [R20]
		else $error("overflow reset missing");
	a_key_reset: assert property (key_bad && srst_cnt == 12'(SRESET_CYC - 1) |=> // [R19]
		DEVICE_RESET && key_reset_flag)
		else $error("key reset not issued");
	a_pin_wake: assert property (pin_wake && !int_wake && !wd_ovf && !halt_take |=> // [R12]
		WAKE_RESUME && !WAKE_IRQ)
		else $error("pin wake did not resume");
	a_hs_flag_low: assert property ($rose(CLK_GATES.hs_on) |-> !hs_flag ##1 !hs_flag) // [R22]
		else $error("stable flag high too early");

	c_sleep: cover property (halt_take && !fast_keep && !slow_keep);
	c_pin_wake: cover property (WAKE_RESUME);
	c_irq_wake: cover property (WAKE_IRQ);
	c_key_reset: cover property (srst_done);
endmodule // lpwd_top
`default_nettype wire

// >>> src/lpwd_pkg.sv
`default_nettype none
package lpwd_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_SYSCLK = 8'h00;
	localparam logic [7:0] OFS_HSOSC = 8'h04;
	localparam logic [7:0] OFS_WDOG = 8'h08;
	localparam logic [7:0] OFS_PAWAKE = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_RSTCAUSE = 8'h14;
	// Field positions
	localparam int SYSSEL_MSB = 7;
	localparam int SYSSEL_LSB = 5;
	localparam int FKEEP_BIT = 1;
	localparam int SKEEP_BIT = 0;
	localparam int HSEN_BIT = 0;
	localparam int HSFLAG_BIT = 1;
	localparam int WDKEY_MSB = 7;
	localparam int WDKEY_LSB = 3;
	localparam int WDSEL_MSB = 2;
	localparam int WDSEL_LSB = 0;
	localparam int PD_BIT = 0;
	localparam int TO_BIT = 1;
	localparam int MODE_LSB = 2;
	localparam int WRF_BIT = 0;
	// Reset values
	localparam logic [7:0] SYSCLK_RST = 8'h00;
	localparam logic [7:0] HSOSC_RST = 8'h01;
	localparam logic [7:0] WDOG_RST = 8'h53;
	localparam logic [7:0] PAWAKE_RST = 8'h00;
	// Codes
	localparam logic [2:0] SEL_SLOW = 3'h7;
	localparam logic [4:0] KEY_DIS = 5'h15;
	localparam logic [4:0] KEY_EN = 5'h0A;
	// Timing
	localparam int CLK_MHZ = 25;
	localparam int SRESET_NS = 50000;
	localparam int SRESET_CYC = (SRESET_NS * CLK_MHZ + 999) / 1000;
	localparam int WD_W = 18;
	localparam int PA_W = 8;

	typedef enum {MODE_RUN, MODE_SLEEP, MODE_IDLE_SLOW, MODE_IDLE_BOTH, MODE_IDLE_FAST} lpwd_mode_t;

	// Clock and function enables sent to the clock tree
	typedef struct packed {
		logic hs_on;
		logic ls_on;
		logic cpu_run;
		logic wd_run;
	} lpwd_gates_t;

	// Terminal count of the watchdog for a period code
	function automatic logic [WD_W-1:0] wd_limit(input logic [2:0] sel);
		logic [WD_W-1:0] lim;
		lim = '0;
		unique case (sel)
			3'h0: lim = 18'h000FF;
			3'h1: lim = 18'h003FF;
			3'h2: lim = 18'h00FFF;
			3'h3: lim = 18'h03FFF;
			3'h4: lim = 18'h07FFF;
			3'h5: lim = 18'h0FFFF;
			3'h6: lim = 18'h1FFFF;
			3'h7: lim = 18'h3FFFF;
		endcase
		return lim;
	endfunction
endpackage
`default_nettype wire

// >>> src/lpwd_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module lpwd_pin_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// Three-stage capture
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Accept a level once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dout <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2[i] == s3[i]) begin
					dout[i] <= s3[i];
				end
			end
		end
	end
endmodule // lpwd_pin_sync
`default_nettype wire

// >>> testbench/lpwd_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lpwd_top_tb
	import lpwd_pkg::*;
;
	logic clk, rst_n, cyc, stb, we, ack, halt, wdclr, sfull, hsr;
	logic lrc = 1'b0;
	logic wres, wirq, pcsp, drst;
	logic [7:0] adr, ireq, ien, pa;
	logic [3:0] sel;
	logic [31:0] dw, dr, r;
	logic [2:0] ssel;
	logic [2:0] lcnt = 3'h0;
	lpwd_gates_t gates;
	logic [3:0] ev;
	logic [2:0] md [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
	logic [3:0] gt [4] = '{4'h0, 4'h4, 4'h8, 4'hC};
	int n_fail = 0;
	int checks_done = 0;
	int n;
	assign ev = {drst, pcsp, wirq, wres};

	lpwd_top i_dut (.CLK(clk), .RESETN(rst_n), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we),
		.WB_ADR(adr), .WB_SEL(sel), .WB_DAT_W(dw), .WB_DAT_R(dr), .WB_ACK(ack),
		.HALT_EXEC(halt), .WDCLR_EXEC(wdclr), .INT_REQ(ireq), .INT_EN(ien),
		.STACK_FULL(sfull), .PORT_A(pa), .LRC_CLK_IN(lrc), .HSOSC_READY(hsr),
		.SYSCLK_SEL(ssel), .CLK_GATES(gates), .WAKE_RESUME(wres), .WAKE_IRQ(wirq),
		.PC_SP_RESET(pcsp), .DEVICE_RESET(drst));

	// Clock at 25 MHz
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Low RC clock, one rising edge every 8 cycles
	always @(posedge clk) begin
		lcnt <= lcnt + 3'h1;
		lrc <= lcnt[2];
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic single Wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s = 4'h1);
		@(posedge clk);
		cyc <= 1'b1;
		sel <= s;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dw <= {24'h000000, d};
		do @(posedge clk); while (ack !== 1'b1);
		r = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 8'h00);
		chk(r, e);
	endtask

	task automatic pulse(input int k);
		@(posedge clk);
		if (k == 0) halt <= 1'b1; else wdclr <= 1'b1;
		@(posedge clk);
		halt <= 1'b0;
		wdclr <= 1'b0;
	endtask

	// Count edges until the chosen event pulse or the limit
	task automatic wait_for(input int k, input int lim);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (n < lim && ev[k] !== 1'b1);
	endtask

	task automatic t_regs();
		rd(OFS_SYSCLK, 32'h0);
		rd(OFS_HSOSC, 32'h1);
		rd(OFS_WDOG, 32'h53);
		wb(1'b1, OFS_PAWAKE, 8'h5A, 4'h0); // Low byte lane off, write refused
		rd(OFS_PAWAKE, 32'h0);
		rd(OFS_RSTCAUSE, 32'h0);
		wb(1'b1, OFS_STATUS, 8'hFF);
		rd(OFS_STATUS, 32'h0);
		rd(8'h18, 32'h0);
		chk(gates, 4'hF);
	endtask

	task automatic t_sysclk();
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, OFS_SYSCLK, 8'(i << 5));
			repeat (2) @(posedge clk);
			chk(ssel, i);
		end
		hsr <= 1'b1;
		wb(1'b1, OFS_HSOSC, 8'h00);
		rd(OFS_HSOSC, 32'h0);
		wb(1'b1, OFS_HSOSC, 8'h01);
		rd(OFS_HSOSC, 32'h1);
		// Poll the stable flag before relying on the fast clock
		n = 0;
		do begin
			wb(1'b0, OFS_HSOSC, 8'h00);
			n++;
		end while (r[1] !== 1'b1 && n < 20);
		chk(r, 32'h3);
	endtask

	task automatic t_modes();
		wb(1'b1, OFS_WDOG, 8'hAB);
		wb(1'b1, OFS_PAWAKE, 8'h01);
		for (int k = 0; k < 4; k++) begin
			wb(1'b1, OFS_SYSCLK, 8'(k));
			pulse(0);
			rd(OFS_STATUS, {27'h0, md[k], 2'b01});
			chk(gates, gt[k]);
			pa[0] <= 1'b0;
			wait_for(0, 20);
			chk(n < 20, 1);
			pa[0] <= 1'b1;
			rd(OFS_STATUS, 32'h1);
		end
		pulse(1);
		rd(OFS_STATUS, 32'h0);
	endtask

	task automatic t_ints();
		wb(1'b1, OFS_SYSCLK, 8'h00);
		ien <= 8'h01;
		pulse(0);
		ireq[0] <= 1'b1;
		wait_for(1, 20);
		chk(n < 20, 1);
		ireq <= 8'h00;
		sfull <= 1'b1;
		pulse(0);
		ireq[0] <= 1'b1;
		wait_for(0, 20);
		chk(n < 20, 1);
		ireq <= 8'h02;
		sfull <= 1'b0;
		pulse(0);
		pa[1] <= 1'b0;
		wait_for(0, 30);
		chk(n, 30);
		pa <= 8'hFE;
		wait_for(0, 20);
		chk(n < 20, 1);
		pa <= 8'hFF;
		ireq <= 8'h00;
	endtask

	task automatic t_wdog();
		wb(1'b1, OFS_WDOG, 8'h50);
		repeat (400) @(posedge clk); // Counter advances before halt clears it
		pulse(0);
		wait_for(2, 2200);
		chk(n > 2030 && n < 2070, 1);
		rd(OFS_STATUS, 32'h3);
		repeat (400) @(posedge clk); // Counter advances before the clear
		pulse(1);
		wait_for(3, 2200);
		chk(n > 2030 && n < 2070, 1);
		rd(OFS_STATUS, 32'h2);
		rd(OFS_WDOG, 32'h53);
	endtask

	task automatic t_key();
		wb(1'b1, OFS_WDOG, 8'h00);
		wait_for(3, 1400);
		chk(n > SRESET_CYC - 10 && n < SRESET_CYC + 10, 1);
		rd(OFS_RSTCAUSE, 32'h1);
		wb(1'b1, OFS_RSTCAUSE, 8'h00);
		rd(OFS_RSTCAUSE, 32'h0);
	endtask

	// Stimulus sequence after a 20-cycle reset
	initial begin
		rst_n = 1'b0;
		{cyc, stb, we, halt, wdclr, sfull, hsr} = '0;
		adr = 8'h00;
		sel = 4'h1;
		dw = 32'h0;
		ireq = 8'h00;
		ien = 8'h00;
		pa = 8'hFF;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_sysclk();
		t_modes();
		t_ints();
		t_wdog();
		t_key();
		wrap_up();
	end

	// Watchdog on the whole run
	initial begin
		#(20000 * 40);
		n_fail++;
		wrap_up();
	end
endmodule // lpwd_top_tb
`default_nettype wire
